// ===== logic/pdwc_consts.svh
// constants for the power-down and wake-up control block
`ifndef PDWC_CONSTS_SVH
`define PDWC_CONSTS_SVH

// register byte offsets
`define PDWC_CTRL_OFS     8'h00
`define PDWC_STAT_OFS     8'h04
`define PDWC_WCNT_OFS     8'h08

// control register fields
`define PDWC_SWEN_BIT     0
`define PDWC_PS_LSB       1
`define PDWC_PS_MSB       4

// reset values
`define PDWC_SWEN_RST     1'b0
`define PDWC_PS_RST       4'h4
`define PDWC_PDF_RST      1'b1
`define PDWC_TOF_RST      1'b1

// watchdog period: base prescale and largest legal select
`define PDWC_WDT_BASE     20'h00020
`define PDWC_PS_MAX       4'hB

// start-up delay: figure in oscillator periods, clock period in ns
`define PDWC_OST_TOSC     1024
`define PDWC_TOSC_NS      10
`define PDWC_CLK_NS       10
`define PDWC_OST_CYC \
  ((`PDWC_OST_TOSC * `PDWC_TOSC_NS + `PDWC_CLK_NS - 1) / `PDWC_CLK_NS)

// interrupt vector address
`define PDWC_VEC_ADDR     13'h0004

// bus responses
`define PDWC_RESP_OKAY    2'h0
`define PDWC_RESP_SLVERR  2'h2

`endif

// ===== logic/pdwc_pkg.sv
// types of the power-down and wake-up control block
package pdwc_pkg;

  // sequencer states
  typedef enum logic [1:0] {
    PDWC_RUN    = 2'b00,
    PDWC_HALT   = 2'b01,
    PDWC_OSTW   = 2'b10,
    PDWC_RESUME = 2'b11
  } pdwc_state_type;

  // requests from the processor core
  typedef struct packed {
    logic sleep;    // power-down instruction executes
    logic watchdog_clear_instruction;   // watchdog clear instruction executes
    logic global_irq_enable;      // global_irq_enable
    logic peripheral_irq_enable;     // peripheral_irq_enable
  } pdwc_core_req_type;

  // answers to the processor core
  typedef struct packed {
    logic        prefetch;   // fetch next address now
    logic        resume;     // continue execution
    logic        vector;     // branch after the next instruction
    logic [12:0] vec_addr;
  } pdwc_core_ack_type;

endpackage : pdwc_pkg

// ===== logic/pdwc_power_down_wakeup_control.sv
// power-down and wake-up sequencer with watchdog and register slave
//
// How it works
// - halt with watchdog on clears its count; it keeps counting.
// - halt clears power_down_flag and sets timeout_flag.
// - halt switches off the oscillator driver.
// - ports hold their drive state while halted.
// - watchdog reset never drives the external reset pin.
// - wake on pin reset, watchdog expiry or enabled interrupt.
// - pin wake resets the device; others resume execution.
// - power_down_flag set at power-up, cleared by a halt.
// - watchdog wake clears timeout_flag.
// - only the listed asynchronous sources may wake the device.
// - clocked peripherals cannot wake the halted device.
// - halt instruction triggers prefetch of the next address.
// - wake needs source enable, plus peripheral enable for peripheral sources; not global.
// - after interrupt wake, branch to 0004h if global enable set.
// - watchdog count is cleared on every wake.
// - pending enabled flag before halt makes the halt a nop.
// - flag set during or after halt completes it, then wakes.
// - crystal mode waits 1024 oscillator periods before running; only after watchdog or interrupt wake, not at power-up or pin wake.
// - watchdog held cleared while the start-up timer counts.
// - config enable forces watchdog on; else soft enable rules.
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pdwc_consts.svh"

module pdwc_power_down_wakeup_control
  import pdwc_pkg::*;
#(
  parameter int NSRC       = 8,
  parameter int AW         = 8,
  parameter int OST_CYC    = `PDWC_OST_CYC,
  parameter logic [NSRC-1:0] WAKE_MASK = 8'h7F,
  parameter logic [NSRC-1:0] PERI_MASK = 8'h9F
) (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  // core side
  input  wire pdwc_core_req_type core_req_i,
  output var  pdwc_core_ack_type core_ack_o,
  // interrupt flags and enables
  input  wire logic [NSRC-1:0]   irq_flag_i,
  input  wire logic [NSRC-1:0]   irq_en_i,
  // configuration
  input  wire logic              watchdog_config_enable_i,
  input  wire logic              xtal_mode_i,
  // external reset pin, active low
  input  wire logic              external_reset_pin_n_i,
  // power and reset outputs
  output logic                   osc_drv_en_o,
  output logic                   port_hold_o,
  output logic                   halted_o,
  output logic                   device_reset_o,
  output logic                   wdt_reset_o,
  output logic                   power_down_flag_o,
  output logic                   timeout_flag_o,
  // axi4-lite write address
  input  wire logic [AW-1:0]     s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [AW-1:0]     s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // elaboration checks
  if (NSRC < 1 || NSRC > 32) begin : g_chk_nsrc
    $error("NSRC must be 1 to 32");
  end
  if (AW < 4) begin : g_chk_aw
    $error("AW must be at least 4");
  end
  if (OST_CYC < 1 || OST_CYC > 2047) begin : g_chk_ost
    $error("OST_CYC must be 1 to 2047");
  end

  // whole state of the block
  typedef struct packed {
    logic              pin_s1;
    logic              pin_s2;
    pdwc_state_type    st;
    logic              pdf;
    logic              tof;
    logic              swen;
    logic [3:0]        ps;
    logic [19:0]       wcnt;
    logic [10:0]       oscillator_startup_timer;
    logic              osc_en;
    logic              hold;
    logic              dev_rst;
    logic              wdt_rst;
    pdwc_core_ack_type ack;
    logic              awrdy;
    logic              aw_h;
    logic [AW-1:0]     aw_addr;
    logic              wrdy;
    logic              w_h;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arrdy;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } pdwc_regs_type;

  pdwc_regs_type s_r;
  pdwc_regs_type s_nxt;

  // reset release synchroniser
  logic rst_s1_r;
  logic rst_n_r;

  // combinational helpers
  logic [NSRC-1:0] wake_terms;
  logic            wake_req;
  logic            wdt_on;
  logic [3:0]      ps_eff;
  logic [19:0]     wdt_limit;
  logic            wdt_exp;
  logic            pin_low;

  // reset is asserted at once, released after two edges
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // flag AND enable per source, ORed
  // wake mask keeps the asynchronous sources only
  // clocked sources drop out by the same mask
  // peripheral enable gates peripheral sources; gie does not
  assign wake_terms = irq_flag_i & irq_en_i & WAKE_MASK
                    & (~PERI_MASK | {NSRC{core_req_i.peripheral_irq_enable}});
  assign wake_req   = |wake_terms;

  // config enable overrides the soft enable
  assign wdt_on    = watchdog_config_enable_i | s_r.swen;
  // reserved period codes fall back to the longest period
  assign ps_eff    = (s_r.ps > `PDWC_PS_MAX) ? `PDWC_PS_MAX : s_r.ps;
  assign wdt_limit = `PDWC_WDT_BASE << ps_eff;
  // no expiry while the start-up timer owns the counter
  assign wdt_exp   = wdt_on && (s_r.st != PDWC_OSTW)
                  && (s_r.wcnt == wdt_limit - 20'h00001);
  // only the second synchroniser stage is looked at
  assign pin_low   = !s_r.pin_s2;

  // next state
  always_comb begin
    s_nxt = s_r;
    // one-cycle pulses fall back each cycle
    s_nxt.ack.prefetch = 1'b0;
    s_nxt.ack.resume   = 1'b0;
    s_nxt.wdt_rst      = 1'b0;
    s_nxt.dev_rst      = 1'b0;
    s_nxt.pin_s1       = external_reset_pin_n_i;
    s_nxt.pin_s2       = s_r.pin_s1;

    // watchdog counts in every state but start-up
    if (wdt_on && s_r.st != PDWC_OSTW) begin
      s_nxt.wcnt = s_r.wcnt + 20'h00001;
    end else if (!wdt_on) begin
      s_nxt.wcnt = 20'h00000;
    end

    unique case (s_r.st)
      PDWC_RUN: begin
        // clear instruction restarts the count, flags go high
        if (core_req_i.watchdog_clear_instruction) begin
          s_nxt.wcnt = 20'h00000;
          s_nxt.pdf  = 1'b1;
          s_nxt.tof  = 1'b1;
        end
        if (core_req_i.sleep) begin
          // next address is fetched during the halt
          s_nxt.ack.prefetch = 1'b1;
          // a pending enabled flag turns the halt into a nop
          if (!wake_req) begin
            s_nxt.wcnt   = 20'h00000;
            s_nxt.pdf    = 1'b0;
            s_nxt.tof    = 1'b1;
            s_nxt.osc_en = 1'b0;
            s_nxt.hold   = 1'b1;
            s_nxt.st     = PDWC_HALT;
          end
        end else if (wdt_exp && !core_req_i.watchdog_clear_instruction) begin
          // a clear in the same cycle wins over the expiry
          // internal reset only, pin is never driven
          s_nxt.wdt_rst = 1'b1;
          s_nxt.wcnt    = 20'h00000;
          s_nxt.tof     = 1'b0;
        end
      end
      PDWC_HALT: begin
        // a flag raised after the halt wakes at once
        if (wdt_exp || wake_req) begin
          if (wdt_exp) begin
            s_nxt.tof = 1'b0;
          end
          s_nxt.wcnt   = 20'h00000;
          s_nxt.osc_en = 1'b1;
          s_nxt.oscillator_startup_timer    = 11'h000;
          // only crystal modes wait for the oscillator
          s_nxt.st     = xtal_mode_i ? PDWC_OSTW : PDWC_RESUME;
        end
      end
      PDWC_OSTW: begin
        // watchdog held in reset while the delay runs
        s_nxt.wcnt = 20'h00000;
        s_nxt.oscillator_startup_timer  = s_r.oscillator_startup_timer + 11'h001;
        // start-up delay in whole clock cycles
        if (s_r.oscillator_startup_timer == 11'(OST_CYC - 1)) begin
          s_nxt.st = PDWC_RESUME;
        end
      end
      PDWC_RESUME: begin
        s_nxt.hold       = 1'b0;
        s_nxt.ack.resume = 1'b1;
        // vector taken only with global enable set
        s_nxt.ack.vector = core_req_i.global_irq_enable;
        s_nxt.wcnt       = 20'h00000;
        s_nxt.st         = PDWC_RUN;
      end
    endcase

    // pin reset wins over everything, full device reset
    // pin assertion also ends the halt
    if (pin_low) begin
      s_nxt.dev_rst      = 1'b1;
      s_nxt.st           = PDWC_RUN;
      s_nxt.osc_en       = 1'b1;
      s_nxt.hold         = 1'b0;
      s_nxt.wcnt         = 20'h00000;
      s_nxt.ack.prefetch = 1'b0;
      s_nxt.ack.resume   = 1'b0;
      s_nxt.ack.vector   = 1'b0;
      s_nxt.wdt_rst      = 1'b0;
      s_nxt.swen         = `PDWC_SWEN_RST;
      s_nxt.ps           = `PDWC_PS_RST;
    end

    // write channel: address and data taken in either order
    if (s_r.awrdy && s_axi_awvalid) begin
      s_nxt.awrdy   = 1'b0;
      s_nxt.aw_h    = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_r.wrdy && s_axi_wvalid) begin
      s_nxt.wrdy   = 1'b0;
      s_nxt.w_h    = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    // perform the write once both halves are held
    if (s_r.aw_h && s_r.w_h && !s_r.bvalid) begin
      s_nxt.aw_h   = 1'b0;
      s_nxt.w_h    = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = `PDWC_RESP_OKAY;
      if (s_r.aw_addr == AW'(`PDWC_CTRL_OFS)) begin
        // pin reset in the same cycle keeps priority
        if (s_r.w_strb[0] && !pin_low) begin
          s_nxt.swen = s_r.w_data[`PDWC_SWEN_BIT];
          s_nxt.ps   = s_r.w_data[`PDWC_PS_MSB:`PDWC_PS_LSB];
        end
      end else if (s_r.aw_addr != AW'(`PDWC_STAT_OFS)
                && s_r.aw_addr != AW'(`PDWC_WCNT_OFS)) begin
        s_nxt.bresp = `PDWC_RESP_SLVERR;
      end
    end
    // response taken, reopen both channels
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.awrdy  = 1'b1;
      s_nxt.wrdy   = 1'b1;
    end

    // read channel: one read under way at a time
    if (s_r.arrdy && s_axi_arvalid) begin
      s_nxt.arrdy  = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = `PDWC_RESP_OKAY;
      s_nxt.rdata  = 32'h00000000;
      if (s_axi_araddr == AW'(`PDWC_CTRL_OFS)) begin
        s_nxt.rdata[`PDWC_SWEN_BIT]             = s_r.swen;
        s_nxt.rdata[`PDWC_PS_MSB:`PDWC_PS_LSB] = s_r.ps;
      end else if (s_axi_araddr == AW'(`PDWC_STAT_OFS)) begin
        s_nxt.rdata[0]   = s_r.pdf;
        s_nxt.rdata[1]   = s_r.tof;
        s_nxt.rdata[3:2] = s_r.st;
        s_nxt.rdata[4]   = wdt_on;
        s_nxt.rdata[5]   = wake_req;
      end else if (s_axi_araddr == AW'(`PDWC_WCNT_OFS)) begin
        s_nxt.rdata[19:0] = s_r.wcnt;
      end else begin
        s_nxt.rresp = `PDWC_RESP_SLVERR;
      end
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arrdy  = 1'b1;
    end
  end

  // state register; power-up values, flags high after power-up
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s_r              <= '0;
      s_r.st           <= PDWC_RUN;
      s_r.pin_s1       <= 1'b1;
      s_r.pin_s2       <= 1'b1;
      s_r.pdf          <= `PDWC_PDF_RST;
      s_r.tof          <= `PDWC_TOF_RST;
      s_r.swen         <= `PDWC_SWEN_RST;
      s_r.ps           <= `PDWC_PS_RST;
      s_r.osc_en       <= 1'b1;
      s_r.ack.vec_addr <= `PDWC_VEC_ADDR;
      s_r.awrdy        <= 1'b1;
      s_r.wrdy         <= 1'b1;
      s_r.arrdy        <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign core_ack_o        = s_r.ack;
  assign osc_drv_en_o      = s_r.osc_en;
  assign port_hold_o       = s_r.hold;
  assign halted_o          = s_r.hold;
  assign device_reset_o    = s_r.dev_rst;
  assign wdt_reset_o       = s_r.wdt_rst;
  assign power_down_flag_o = s_r.pdf;
  assign timeout_flag_o    = s_r.tof;
  assign s_axi_awready     = s_r.awrdy;
  assign s_axi_wready      = s_r.wrdy;
  assign s_axi_bresp       = s_r.bresp;
  assign s_axi_bvalid      = s_r.bvalid;
  assign s_axi_arready     = s_r.arrdy;
  assign s_axi_rdata       = s_r.rdata;
  assign s_axi_rresp       = s_r.rresp;
  assign s_axi_rvalid      = s_r.rvalid;

endmodule : pdwc_power_down_wakeup_control
`default_nettype wire

// ===== tb/pdwc_assertions.sv
// port checker of the power-down and wake-up sequencer
`timescale 1ns/1ns
`default_nettype none
module pdwc_assertions
  import pdwc_pkg::*;
#(
  parameter int NSRC = 8,
  parameter int OST_CYC = 8,
  parameter logic [NSRC-1:0] WAKE_MASK = 8'h7F,
  parameter logic [NSRC-1:0] PERI_MASK = 8'h9F
) (
  // clock and reset
  input wire logic              mclk_i,
  input wire logic              rstn_i,
  // core and sources
  input wire pdwc_core_req_type core_req_i,
  input wire pdwc_core_ack_type core_ack_o,
  input wire logic [NSRC-1:0]   irq_flag_i,
  input wire logic [NSRC-1:0]   irq_en_i,
  input wire logic              xtal_mode_i,
  input wire logic              external_reset_pin_n_i,
  // power outputs
  input wire logic              osc_drv_en_o,
  input wire logic              port_hold_o,
  input wire logic              halted_o,
  input wire logic              device_reset_o,
  input wire logic              wdt_reset_o,
  input wire logic              power_down_flag_o,
  input wire logic              timeout_flag_o
);
  localparam int OST_LO = OST_CYC - 1;
  localparam int OST_HI = OST_CYC + 3;
  // wake terms; clocked source bit never counts
  logic [NSRC-1:0] wake_v;
  assign wake_v = irq_flag_i & irq_en_i & WAKE_MASK
                  & (core_req_i.peripheral_irq_enable ? '1 : ~PERI_MASK);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // oscillator back first, resume one cycle later
  sequence resume_s;
    osc_drv_en_o ##1 core_ack_o.resume;
  endsequence
  prefetch_a:
    assert property (core_ack_o.prefetch |-> $past(core_req_i.sleep))
    else $error("prefetch without halt request");
  halt_entry_a:
    assert property ($rose(halted_o) |->
      !osc_drv_en_o && !power_down_flag_o && timeout_flag_o)
    else $error("halt entered with wrong flags or oscillator");
  port_hold_a:
    assert property (port_hold_o == halted_o)
    else $error("port hold differs from halt state");
  osc_off_a:
    assert property (!osc_drv_en_o |-> halted_o)
    else $error("oscillator off outside halt");
  pin_reset_a:
    assert property (!external_reset_pin_n_i [*5] |-> device_reset_o)
    else $error("pin held low without device reset");
  wdt_pin_a:
    assert property (wdt_reset_o |-> !device_reset_o)
    else $error("watchdog expiry drove the pin reset");
  wake_irq_a:
    assert property (halted_o && !osc_drv_en_o && (|wake_v) &&
      !xtal_mode_i && external_reset_pin_n_i && !device_reset_o
      |=> resume_s)
    else $error("enabled interrupt did not wake in time");
  vector_a:
    assert property (core_ack_o.resume |->
      core_ack_o.vector == $past(core_req_i.global_irq_enable) &&
      core_ack_o.vec_addr == 13'h0004)
    else $error("vector choice or address wrong at resume");
  xtal_wait_a:
    assert property ($rose(osc_drv_en_o) && xtal_mode_i &&
      !device_reset_o |-> ##[OST_LO:OST_HI] core_ack_o.resume)
    else $error("crystal start-up delay not kept");
  pdf_clear_a:
    assert property ($fell(power_down_flag_o) |->
      $past(core_req_i.sleep) && !$past(|wake_v))
    else $error("power-down flag cleared without real halt");
endmodule : pdwc_assertions
bind pdwc_power_down_wakeup_control pdwc_assertions #(
  .NSRC(NSRC), .OST_CYC(OST_CYC), .WAKE_MASK(WAKE_MASK),
  .PERI_MASK(PERI_MASK)
) i_pdwc_assertions (
  .mclk_i, .rstn_i, .core_req_i, .core_ack_o, .irq_flag_i, .irq_en_i,
  .xtal_mode_i, .external_reset_pin_n_i, .osc_drv_en_o, .port_hold_o,
  .halted_o, .device_reset_o, .wdt_reset_o, .power_down_flag_o,
  .timeout_flag_o
);
`default_nettype wire

// ===== tb/pdwc_core_model.sv
// core, interrupt source and reset pin model
`timescale 1ns/1ns
`default_nettype none
module pdwc_core_model
  import pdwc_pkg::*;
(
  // clock and answers
  input  wire logic              mclk_i,
  input  wire pdwc_core_ack_type core_ack_i,
  // requests and sources
  output var  pdwc_core_req_type core_req_o,
  output var  logic [7:0]        irq_flag_o,
  output var  logic [7:0]        irq_en_o,
  output var  logic              pin_n_o
);
  int n_resume = 0;
  // quiet core, pin released high
  initial begin
    core_req_o = '0;
    irq_flag_o = 8'h00;
    irq_en_o = 8'h00;
    pin_n_o = 1'b1;
  end
  // resume pulses, so a pin wake can be told apart
  always @(posedge mclk_i) begin
    if (core_ack_i.resume === 1'b1) n_resume++;
  end
  // halt instruction, one-cycle request
  task automatic sleep_op(input logic global_irq_enable);
    @(posedge mclk_i);
    core_req_o.global_irq_enable <= global_irq_enable;
    core_req_o.watchdog_clear_instruction <= !global_irq_enable;
    @(posedge mclk_i);
    core_req_o.watchdog_clear_instruction <= 1'b0;
    core_req_o.sleep <= 1'b1;
    @(posedge mclk_i);
    core_req_o.sleep <= 1'b0;
  endtask : sleep_op
  // source flags, enables and peripheral gate
  task automatic set_irq(input logic [7:0] f, e, input logic pe);
    @(posedge mclk_i);
    irq_flag_o <= f;
    irq_en_o <= e;
    core_req_o.peripheral_irq_enable <= pe;
  endtask : set_irq
  // pin held low for a number of cycles
  task automatic pin_low(input int c);
    @(posedge mclk_i);
    pin_n_o <= 1'b0;
    repeat (c) @(posedge mclk_i);
    pin_n_o <= 1'b1;
  endtask : pin_low
endmodule : pdwc_core_model
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench of the power-down sequencer
`timescale 1ns/1ns
`default_nettype none
`include "pdwc_consts.svh"
module tb_top;
  import pdwc_pkg::*;
  localparam int OSCILLATOR_STARTUP_TIMER = 8;
  localparam logic [31:0] T = 32'h1, F = 32'h0, M = 32'hFFFFFFFF;
  localparam logic [1:0] OK = `PDWC_RESP_OKAY, SE = `PDWC_RESP_SLVERR;
  localparam logic [7:0] CT = `PDWC_CTRL_OFS, ST = `PDWC_STAT_OFS;
  logic mclk_i = 1'b0, rstn_i = 1'b0;
  logic watchdog_config_enable_i = 1'b0, xtal_mode_i = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  pdwc_core_req_type core_req_i;
  pdwc_core_ack_type core_ack_o;
  logic [7:0] irq_flag_i, irq_en_i;
  logic external_reset_pin_n_i, osc_drv_en_o, port_hold_o, halted_o;
  logic device_reset_o, wdt_reset_o, power_down_flag_o, timeout_flag_o;
  int n_mismatch = 0, check_count = 0, n;
  // free-running 100 MHz clock
  always #5 mclk_i = ~mclk_i;
  pdwc_power_down_wakeup_control #(.OST_CYC(OSCILLATOR_STARTUP_TIMER))
    i_pdwc_power_down_wakeup_control (
    .mclk_i, .rstn_i, .core_req_i, .core_ack_o, .irq_flag_i, .irq_en_i,
    .watchdog_config_enable_i, .xtal_mode_i, .external_reset_pin_n_i,
    .osc_drv_en_o, .port_hold_o, .halted_o, .device_reset_o,
    .wdt_reset_o, .power_down_flag_o, .timeout_flag_o,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  pdwc_core_model i_pdwc_core_model (.mclk_i, .core_ack_i(core_ack_o),
    .core_req_o(core_req_i), .irq_flag_o(irq_flag_i),
    .irq_en_o(irq_en_i), .pin_n_o(external_reset_pin_n_i));
  task automatic chk(input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("FAIL at %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  // one edge, then let its updates land
  task automatic step;
    @(posedge mclk_i);
    #1;
  endtask : step
  task automatic wait_res(output int c);
    c = 0;
    do begin
      step();
      c++;
    end while (core_ack_o.resume !== 1'b1 && c < 200);
  endtask : wait_res
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    int t;
    hb = 1'b0;
    r = 2'h3;
    t = 0;
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!hb && t < 50) begin
      #1;
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge mclk_i);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
      t++;
    end
    if (!hb) n_mismatch++;
    chk(32'(r), 32'(er));
  endtask : wr
  // read and compare the masked word and the response
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
                    input logic [1:0] er);
    logic ha, hr;
    logic [31:0] d;
    logic [1:0] r;
    int t;
    hr = 1'b0;
    d = 32'h0;
    r = 2'h3;
    t = 0;
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!hr && t < 50) begin
      #1;
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk_i);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) s_axi_rready <= 1'b0;
      t++;
    end
    if (!hr) n_mismatch++;
    chk(d & m, e);
    chk(32'(r), 32'(er));
  endtask : rd
  task automatic results;
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // hang guard, far beyond the expected run
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rd(CT, 32'h8, M, OK);
    rd(ST, 32'h3, M, OK);
    chk(32'(osc_drv_en_o), T);
    rd(8'h0C, F, M, SE);
    wr(8'h0C, T, SE);
    wr(ST, 32'hFF, OK);
    rd(ST, 32'h3, M, OK);
    wr(CT, T, OK);
    n = 0;
    do begin
      step();
      n++;
    end while (wdt_reset_o !== 1'b1 && n < 80);
    chk(32'(wdt_reset_o), T);
    chk(32'(device_reset_o), F);
    step();
    chk(32'(timeout_flag_o), F);
    wr(CT, F, OK);
    watchdog_config_enable_i <= 1'b1;
    rd(ST, 32'h10, 32'h10, OK);
    watchdog_config_enable_i <= 1'b0;
    rd(ST, F, 32'h10, OK);
    // pending enabled flag: halt becomes a nop
    i_pdwc_core_model.set_irq(8'h01, 8'h01, 1'b1);
    rd(ST, 32'h20, 32'h20, OK);
    i_pdwc_core_model.sleep_op(1'b0);
    #1;
    chk(32'(core_ack_o.prefetch), T);
    chk(32'({halted_o, power_down_flag_o}), T);
    // clocked source and ungated peripheral must not wake
    i_pdwc_core_model.set_irq(8'h81, 8'h81, 1'b0);
    i_pdwc_core_model.sleep_op(1'b1);
    #1;
    chk(32'(core_ack_o.prefetch), T);
    chk(32'({halted_o, port_hold_o, osc_drv_en_o, power_down_flag_o,
      timeout_flag_o}), 32'h19);
    repeat (6) step();
    chk(32'(halted_o), T);
    i_pdwc_core_model.set_irq(8'hA1, 8'hA1, 1'b0);
    wait_res(n);
    chk(32'(n), 32'h2);
    chk(32'({core_ack_o.vector, halted_o}), 32'h2);
    chk(32'(core_ack_o.vec_addr), 32'h4);
    // crystal mode: start-up wait, then in-line resume
    @(posedge mclk_i) xtal_mode_i <= 1'b1;
    i_pdwc_core_model.set_irq(8'h00, 8'h40, 1'b0);
    i_pdwc_core_model.sleep_op(1'b0);
    i_pdwc_core_model.set_irq(8'h40, 8'h40, 1'b0);
    wait_res(n);
    chk(32'(n >= OSCILLATOR_STARTUP_TIMER && n <= OSCILLATOR_STARTUP_TIMER + 5), T);
    chk(32'(core_ack_o.vector), F);
    @(posedge mclk_i) xtal_mode_i <= 1'b0;
    i_pdwc_core_model.set_irq(8'h00, 8'h00, 1'b0);
    // watchdog expiry ends the halt, period of 32 clocks
    wr(CT, T, OK);
    i_pdwc_core_model.sleep_op(1'b0);
    wait_res(n);
    chk(32'(n >= 31 && n <= 36), T);
    chk(32'({power_down_flag_o, timeout_flag_o}), F);
    // pin wake: full reset, no resume
    wr(CT, 32'h18, OK);
    rd(CT, 32'h18, M, OK);
    i_pdwc_core_model.sleep_op(1'b0);
    n = i_pdwc_core_model.n_resume;
    i_pdwc_core_model.pin_low(6);
    #1;
    chk(32'(device_reset_o), T);
    repeat (4) step();
    chk(32'({halted_o, power_down_flag_o}), F);
    chk(32'(i_pdwc_core_model.n_resume - n), F);
    repeat (4) step();
    rd(CT, 32'h8, M, OK);
    // lane 0 strobe low: control write is ignored
    s_axi_wstrb <= 4'hE;
    wr(CT, 32'h1F, OK);
    s_axi_wstrb <= 4'hF;
    rd(CT, 32'h8, M, OK);
    results();
  end
endmodule : tb_top
`default_nettype wire
